// ==== design/sadp_cvt.sv ====
// package of store path constants and double-to-single converter
`timescale 1ns/1ps
package sadp_pkg;
  localparam int PRI_MSB = 31;
  localparam int PRI_LSB = 26;
  localparam int SRC_MSB = 25;
  localparam int SRC_LSB = 21;
  localparam int BAS_MSB = 20;
  localparam int BAS_LSB = 16;
  localparam int IDX_MSB = 15;
  localparam int IDX_LSB = 11;
  localparam int DSP_MSB = 15;
  localparam int XO_MSB = 10;
  localparam int XO_LSB = 1;
  localparam logic [5:0] OP_BYTE = 6'h26;
  localparam logic [5:0] OP_BYTE_U = 6'h27;
  localparam logic [5:0] OP_HALF = 6'h2C;
  localparam logic [5:0] OP_HALF_U = 6'h2D;
  localparam logic [5:0] OP_FSGL = 6'h34;
  localparam logic [5:0] OP_FSGL_U = 6'h35;
  localparam logic [5:0] OP_FDBL = 6'h36;
  localparam logic [5:0] OP_FDBL_U = 6'h37;
  localparam logic [5:0] OP_EXT = 6'h1F;
  localparam logic [9:0] XO_BYTE = 10'h0D7;
  localparam logic [9:0] XO_BYTE_U = 10'h0F7;
  localparam logic [9:0] XO_HALF = 10'h197;
  localparam logic [9:0] XO_HALF_U = 10'h1B7;
  localparam logic [9:0] XO_HALF_BR = 10'h396;
  localparam logic [9:0] XO_FSGL = 10'h297;
  localparam logic [9:0] XO_FSGL_U = 10'h2B7;
  localparam logic [9:0] XO_FDBL = 10'h2D7;
  localparam logic [9:0] XO_FDBL_U = 10'h2F7;
  localparam logic [9:0] XO_FIW = 10'h3D7;
  // optional float-as-integer word store present
  localparam logic FIW_SUPPORTED = 1'b1;
  localparam logic [4:0] GPR_ZERO = 5'h00;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_DBL = 2'h3;
  localparam logic [10:0] EXP_NORM_MIN = 11'h381;
  localparam logic [10:0] EXP_DEN_MIN = 11'h36A;
  localparam logic [10:0] EXP_ZERO = 11'h000;
  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_BYTE = 3'h1,
    K_HALF = 3'h3,
    K_HALF_BR = 3'h2,
    K_FSGL = 3'h6,
    K_FDBL = 3'h7,
    K_FIW = 3'h5
  } sadp_kind_type;
endpackage

module sadp_cvt (
  input wire logic [63:0] dbl,
  output logic [31:0] sgl
);
  import sadp_pkg::*;
  logic [10:0] expo;
  logic [23:0] mant;
  logic [10:0] shamt;
  assign expo = dbl[62:52];
  assign mant = {1'b1, dbl[51:29]};
  assign shamt = EXP_NORM_MIN - expo;
  always_comb begin
    if (expo >= EXP_NORM_MIN || expo == EXP_ZERO || expo < EXP_DEN_MIN) begin
      // sign, exponent msb and low seven bits, leading 23 fraction bits
      sgl = {dbl[63:62], dbl[58:29]};
    end else begin
      // below single normal range: denormalise
      sgl = {dbl[63], 8'h00, 23'(mant >> shamt)};
    end
  end
endmodule // sadp_cvt

// ==== design/sadp_top.sv ====
// store address and data path: decode, address, data format, write-back
`timescale 1ns/1ps
module sadp_top (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic ISSUE_VALID,
  input wire logic [31:0] INSTR,
  input wire logic [31:0] BASE_GPR_VAL,
  input wire logic [31:0] INDEX_GPR_VAL,
  input wire logic [31:0] SOURCE_GPR_VAL,
  input wire logic [63:0] SOURCE_FPR_VAL,
  output logic [4:0] BASE_GPR_SEL,
  output logic [4:0] INDEX_GPR_SEL,
  output logic [4:0] SOURCE_SEL,
  output logic MEM_WR_VALID,
  output logic [31:0] MEM_ADDR,
  output logic [1:0] MEM_SIZE,
  output logic [63:0] MEM_DATA,
  output logic GPR_WR_VALID,
  output logic [4:0] GPR_WR_ADDR,
  output logic [31:0] GPR_WR_DATA,
  output logic ILLEGAL
);
  import sadp_pkg::*;
  sadp_kind_type kind;
  logic upd;
  logic indexed;
  logic [5:0] prim;
  logic [9:0] xo;
  logic [4:0] base_fld;
  logic [31:0] base_opnd;
  logic [31:0] offset;
  logic [31:0] ea;
  logic [31:0] sgl_word;
  logic [1:0] size;
  logic [63:0] data;
  logic bad_form;
  logic go;
  logic mem_wr_valid_ff;
  logic [31:0] mem_addr_ff;
  logic [1:0] mem_size_ff;
  logic [63:0] mem_data_ff;
  logic gpr_wr_valid_ff;
  logic [4:0] gpr_wr_addr_ff;
  logic [31:0] gpr_wr_data_ff;
  logic illegal_ff;

  assign prim = INSTR[PRI_MSB:PRI_LSB];
  assign xo = INSTR[XO_MSB:XO_LSB];
  assign base_fld = INSTR[BAS_MSB:BAS_LSB];
  assign BASE_GPR_SEL = base_fld;
  assign INDEX_GPR_SEL = INSTR[IDX_MSB:IDX_LSB];
  assign SOURCE_SEL = INSTR[SRC_MSB:SRC_LSB];

  // opcode decode
  always_comb begin
    kind = K_NONE;
    upd = 1'b0;
    indexed = 1'b0;
    unique case (prim)
      OP_BYTE, OP_BYTE_U: kind = K_BYTE;
      OP_HALF, OP_HALF_U: kind = K_HALF;
      OP_FSGL, OP_FSGL_U: kind = K_FSGL;
      OP_FDBL, OP_FDBL_U: kind = K_FDBL;
      OP_EXT: begin
        indexed = 1'b1;
        unique case (xo)
          XO_BYTE, XO_BYTE_U: kind = K_BYTE;
          XO_HALF, XO_HALF_U: kind = K_HALF;
          XO_HALF_BR: kind = K_HALF_BR;
          XO_FSGL, XO_FSGL_U: kind = K_FSGL;
          XO_FDBL, XO_FDBL_U: kind = K_FDBL;
          XO_FIW: kind = FIW_SUPPORTED ? K_FIW : K_NONE;
          default: kind = K_NONE;
        endcase
        upd = (xo == XO_BYTE_U) || (xo == XO_HALF_U) ||
              (xo == XO_FSGL_U) || (xo == XO_FDBL_U);
      end
      default: kind = K_NONE;
    endcase
    if (!indexed) begin
      upd = prim[0] && (kind != K_NONE);
    end
  end

  // update with base field 0 is refused as an invalid form
  assign bad_form = upd && (base_fld == GPR_ZERO);
  assign go = ISSUE_VALID && (kind != K_NONE) && !bad_form;

  // effective address
  always_comb begin
    if (!upd && base_fld == GPR_ZERO) begin
      base_opnd = '0;
    end else begin
      base_opnd = BASE_GPR_VAL;
    end
    if (indexed) begin
      offset = INDEX_GPR_VAL;
    end else begin
      offset = {{16{INSTR[DSP_MSB]}}, INSTR[DSP_MSB:0]};
    end
  end
  assign ea = base_opnd + offset;

  sadp_cvt u_cvt (
    .dbl(SOURCE_FPR_VAL),
    .sgl(sgl_word)
  );

  // store data, right-justified, most significant byte at lowest address
  always_comb begin
    size = SZ_WORD;
    data = '0;
    unique case (kind)
      K_BYTE: begin
        size = SZ_BYTE;
        data = {56'h0, SOURCE_GPR_VAL[7:0]};
      end
      K_HALF: begin
        size = SZ_HALF;
        data = {48'h0, SOURCE_GPR_VAL[15:0]};
      end
      K_HALF_BR: begin
        size = SZ_HALF;
        data = {48'h0, SOURCE_GPR_VAL[7:0], SOURCE_GPR_VAL[15:8]};
      end
      K_FSGL: begin
        data = {32'h0, sgl_word};
      end
      K_FDBL: begin
        size = SZ_DBL;
        data = SOURCE_FPR_VAL;
      end
      K_FIW: begin
        // single-produced sources give a word left undefined; low word kept
        data = {32'h0, SOURCE_FPR_VAL[31:0]};
      end
      K_NONE: begin
        size = SZ_WORD;
        data = '0;
      end
    endcase
  end

  // memory write request
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      mem_wr_valid_ff <= 1'b0;
      mem_addr_ff <= '0;
      mem_size_ff <= SZ_BYTE;
      mem_data_ff <= '0;
    end else begin
      mem_wr_valid_ff <= go;
      if (go) begin
        mem_addr_ff <= ea;
        mem_size_ff <= size;
        mem_data_ff <= data;
      end
    end
  end

  // base register write-back for update forms
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      gpr_wr_valid_ff <= 1'b0;
      gpr_wr_addr_ff <= '0;
      gpr_wr_data_ff <= '0;
    end else begin
      gpr_wr_valid_ff <= go && upd;
      if (go && upd) begin
        gpr_wr_addr_ff <= base_fld;
        gpr_wr_data_ff <= ea;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      illegal_ff <= 1'b0;
    end else begin
      illegal_ff <= ISSUE_VALID && ((kind == K_NONE) || bad_form);
    end
  end

  assign MEM_WR_VALID = mem_wr_valid_ff;
  assign MEM_ADDR = mem_addr_ff;
  assign MEM_SIZE = mem_size_ff;
  assign MEM_DATA = mem_data_ff;
  assign GPR_WR_VALID = gpr_wr_valid_ff;
  assign GPR_WR_ADDR = gpr_wr_addr_ff;
  assign GPR_WR_DATA = gpr_wr_data_ff;
  assign ILLEGAL = illegal_ff;

  chk_byte_data: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    go && kind == K_BYTE |=> MEM_WR_VALID && MEM_SIZE == SZ_BYTE &&
      MEM_DATA == {56'h0, $past(SOURCE_GPR_VAL[7:0])})
    else $error("byte store data wrong");

  chk_zero_base: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    go && indexed && !upd && base_fld == GPR_ZERO |=>
      MEM_ADDR == $past(INDEX_GPR_VAL))
    else $error("indexed address with zero base wrong");

  chk_disp_upd: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    go && !indexed && upd |=> MEM_ADDR == 32'($past(BASE_GPR_VAL) +
      {{16{$past(INSTR[DSP_MSB])}}, $past(INSTR[DSP_MSB:0])}))
    else $error("displacement update address wrong");

  chk_idx_upd: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    go && indexed && upd |=>
      MEM_ADDR == 32'($past(BASE_GPR_VAL) + $past(INDEX_GPR_VAL)))
    else $error("indexed update address wrong");

  chk_upd_wback: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    GPR_WR_VALID |-> MEM_WR_VALID && GPR_WR_DATA == MEM_ADDR &&
      GPR_WR_ADDR == $past(base_fld))
    else $error("update write-back mismatch");

  chk_half_data: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    go && kind == K_HALF |=> MEM_SIZE == SZ_HALF &&
      MEM_DATA[15:0] == $past(SOURCE_GPR_VAL[15:0]))
    else $error("halfword store data wrong");

  chk_half_swap: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    go && kind == K_HALF_BR |=> MEM_DATA[15:8] == $past(SOURCE_GPR_VAL[7:0])
      && MEM_DATA[7:0] == $past(SOURCE_GPR_VAL[15:8]))
    else $error("byte-reversed halfword wrong");

  chk_dbl_data: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    go && kind == K_FDBL |=> MEM_SIZE == SZ_DBL &&
      MEM_DATA == $past(SOURCE_FPR_VAL))
    else $error("double store data wrong");

  chk_iw_data: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    go && kind == K_FIW |=> MEM_SIZE == SZ_WORD &&
      MEM_DATA[31:0] == $past(SOURCE_FPR_VAL[31:0]))
    else $error("integer word store data wrong");

  chk_no_wback: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    go && !upd |=> MEM_WR_VALID && !GPR_WR_VALID)
    else $error("non-update store wrote a register");
endmodule // sadp_top

// ==== test/sadp_regs_model.sv ====
// register file model on the far side of the store path
`timescale 1ns/1ps
module sadp_regs_model (
  input wire logic clk,
  input wire logic [4:0] base_sel,
  input wire logic [4:0] idx_sel,
  input wire logic [4:0] src_sel,
  input wire logic wr_valid,
  input wire logic [4:0] wr_addr,
  input wire logic [31:0] wr_data,
  output logic [31:0] base_val,
  output logic [31:0] idx_val,
  output logic [31:0] src_val,
  output logic [63:0] fpr_val
);
  logic [31:0] gpr [32];
  logic [63:0] fpr [32];
  initial begin
    for (int i = 0; i < 32; i++) begin
      // register zero is nonzero so a base of zero is visible
      gpr[i] = 32'h0000_1000 * i + 32'h0000_8F7E;
      // low bits clear: exactly representable as single
      fpr[i] = {32'h4009_21F0 + i, 32'hE000_0000};
    end
  end
  assign base_val = gpr[base_sel];
  assign idx_val = gpr[idx_sel];
  assign src_val = gpr[src_sel];
  assign fpr_val = fpr[src_sel];
  always @(posedge clk) begin
    if (wr_valid) begin
      gpr[wr_addr] <= wr_data;
    end
  end
endmodule // sadp_regs_model

// ==== test/sadp_tb_top.sv ====
// self-checking bench for the store address and data path
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, a, b); end end
module sadp_tb_top;
  import sadp_pkg::*;
  logic SYS_CLK = 1'b0, NRST = 1'b0, ISSUE_VALID = 1'b0;
  logic [31:0] INSTR = 32'h0, BASE_GPR_VAL, INDEX_GPR_VAL, SOURCE_GPR_VAL;
  logic [63:0] SOURCE_FPR_VAL, MEM_DATA;
  logic [4:0] BASE_GPR_SEL, INDEX_GPR_SEL, SOURCE_SEL, GPR_WR_ADDR;
  logic MEM_WR_VALID, GPR_WR_VALID, ILLEGAL;
  logic [31:0] MEM_ADDR, GPR_WR_DATA;
  logic [1:0] MEM_SIZE;
  int miscompares = 0, compares = 0, cycles = 0;
  always #25 SYS_CLK = ~SYS_CLK;
  sadp_top u_sadp_top (.SYS_CLK(SYS_CLK), .NRST(NRST),
    .ISSUE_VALID(ISSUE_VALID), .INSTR(INSTR), .BASE_GPR_VAL(BASE_GPR_VAL),
    .INDEX_GPR_VAL(INDEX_GPR_VAL), .SOURCE_GPR_VAL(SOURCE_GPR_VAL),
    .SOURCE_FPR_VAL(SOURCE_FPR_VAL), .BASE_GPR_SEL(BASE_GPR_SEL),
    .INDEX_GPR_SEL(INDEX_GPR_SEL), .SOURCE_SEL(SOURCE_SEL),
    .MEM_WR_VALID(MEM_WR_VALID), .MEM_ADDR(MEM_ADDR), .MEM_SIZE(MEM_SIZE),
    .MEM_DATA(MEM_DATA), .GPR_WR_VALID(GPR_WR_VALID),
    .GPR_WR_ADDR(GPR_WR_ADDR), .GPR_WR_DATA(GPR_WR_DATA), .ILLEGAL(ILLEGAL));
  sadp_regs_model u_sadp_regs_model (.clk(SYS_CLK), .base_sel(BASE_GPR_SEL),
    .idx_sel(INDEX_GPR_SEL), .src_sel(SOURCE_SEL), .wr_valid(GPR_WR_VALID),
    .wr_addr(GPR_WR_ADDR), .wr_data(GPR_WR_DATA), .base_val(BASE_GPR_VAL),
    .idx_val(INDEX_GPR_VAL), .src_val(SOURCE_GPR_VAL),
    .fpr_val(SOURCE_FPR_VAL));
  function automatic logic [31:0] g(input int i);
    return u_sadp_regs_model.gpr[i];
  endfunction
  function automatic logic [31:0] df(input logic [5:0] op,
    input logic [4:0] s, input logic [4:0] a, input logic [15:0] d);
    return {op, s, a, d};
  endfunction
  function automatic logic [31:0] xf(input logic [9:0] xo,
    input logic [4:0] s, input logic [4:0] a, input logic [4:0] b);
    return {OP_EXT, s, a, b, xo, 1'b0};
  endfunction
  task automatic summarize();
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic issue(input logic [31:0] ins);
    @(posedge SYS_CLK);
    ISSUE_VALID <= 1'b1;
    INSTR <= ins;
    @(posedge SYS_CLK);
    ISSUE_VALID <= 1'b0;
    #1;
  endtask
  // one store, then its write and optional base write-back
  task automatic go(input logic [31:0] ins, input logic [31:0] ea,
    input logic [1:0] sz, input logic [63:0] dat, input logic upd);
    issue(ins);
    `CHK(MEM_WR_VALID, 1'b1)
    `CHK(MEM_ADDR, ea)
    `CHK(MEM_SIZE, sz)
    `CHK(MEM_DATA, dat)
    `CHK(GPR_WR_VALID, upd)
    `CHK(ILLEGAL, 1'b0)
    if (upd) `CHK({GPR_WR_ADDR, GPR_WR_DATA}, {ins[20:16], ea})
    @(posedge SYS_CLK);
    #1;
    `CHK({MEM_WR_VALID, GPR_WR_VALID}, 2'b00)
  endtask
  task automatic t_byte();
    logic [63:0] b;
    b = 64'(g(7) & 32'hFF);
    go(df(OP_BYTE, 7, 0, 16'h8004), 32'hFFFF_8004, SZ_BYTE, b, 0);
    go(xf(XO_BYTE, 7, 0, 9), g(9), SZ_BYTE, b, 0);
    go(df(OP_BYTE_U, 7, 5, 16'hFFF0), g(5) - 16, SZ_BYTE, b, 1);
    go(xf(XO_BYTE_U, 7, 6, 9), g(6) + g(9), SZ_BYTE, b, 1);
  endtask
  task automatic t_half();
    logic [31:0] s;
    s = g(7);
    go(df(OP_HALF, 7, 4, 16'h0022), g(4) + 34, SZ_HALF, {48'h0, s[15:0]},
      0);
    go(df(OP_HALF_U, 7, 5, 16'h0002), g(5) + 2, SZ_HALF, {48'h0, s[15:0]},
      1);
    go(xf(XO_HALF, 7, 0, 9), g(9), SZ_HALF, {48'h0, s[15:0]}, 0);
    go(xf(XO_HALF_U, 7, 6, 9), g(6) + g(9), SZ_HALF, {48'h0, s[15:0]},
      1);
    go(xf(XO_HALF_BR, 7, 0, 9), g(9), SZ_HALF, {48'h0, s[7:0], s[15:8]},
      0);
  endtask
  task automatic t_float();
    logic [63:0] f, w;
    f = u_sadp_regs_model.fpr[3];
    // fpr 3 is 400921F3_E0000000: single exponent 80, fraction 490F9F
    w = 64'h0000_0000_4049_0F9F;
    // exponent at the top of the single denormal range, negative
    u_sadp_regs_model.fpr[8] = 64'hB800_0000_0000_0000;
    go(df(OP_FSGL, 8, 0, 16'h0020), 32'h20, SZ_WORD,
      64'h0000_0000_8040_0000, 0);
    go(df(OP_FDBL, 3, 0, 16'h0010), 32'h10, SZ_DBL, f, 0);
    go(df(OP_FDBL_U, 3, 5, 16'h0008), g(5) + 8, SZ_DBL, f, 1);
    go(xf(XO_FDBL, 3, 0, 9), g(9), SZ_DBL, f, 0);
    go(xf(XO_FDBL_U, 3, 6, 9), g(6) + g(9), SZ_DBL, f, 1);
    go(df(OP_FSGL, 3, 4, 16'h0004), g(4) + 4, SZ_WORD, w, 0);
    go(df(OP_FSGL_U, 3, 5, 16'h0004), g(5) + 4, SZ_WORD, w, 1);
    go(xf(XO_FSGL, 3, 0, 9), g(9), SZ_WORD, w, 0);
    go(xf(XO_FSGL_U, 3, 6, 9), g(6) + g(9), SZ_WORD, w, 1);
    go(xf(XO_FIW, 3, 0, 9), g(9), SZ_WORD, {32'h0, f[31:0]},
      0);
  endtask
  task automatic t_refuse();
    logic [31:0] bad [5];
    bad = '{df(OP_BYTE_U, 7, 0, 16'h4), xf(XO_HALF_U, 7, 0, 9),
      df(OP_FDBL_U, 3, 0, 16'h8), xf(10'h338, 7, 5, 3),
      df(6'h0E, 7, 5, 16'h1)};
    foreach (bad[i]) begin
      issue(bad[i]);
      `CHK({ILLEGAL, MEM_WR_VALID, GPR_WR_VALID}, 3'b100)
    end
  endtask
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(posedge SYS_CLK);
    `CHK({MEM_WR_VALID, MEM_SIZE, GPR_WR_VALID, ILLEGAL}, 5'h00)
    NRST <= 1'b1;
    t_byte();
    t_half();
    t_float();
    t_refuse();
    summarize();
  end
endmodule // sadp_tb_top
